// File: bench/battery_charge_control_test.sv
// Self-checking bench for the charge control block, APB plus pin stimulus.
// Assumes TICK_CYCLES is shortened to 4 so timed phases stay brief.
`timescale 1ns/1ps
module battery_charge_control_test;
  logic                  pclk;
  logic                  presetn;
  logic                  psel;
  logic                  penable;
  logic                  pwrite;
  logic [11:0]           paddr;
  logic [31:0]           pwdata;
  logic [31:0]           prdata;
  logic                  pready;
  logic                  pslverr;
  bcc_pkg::bcc_pins_type pins;
  bcc_pkg::bcc_pins_type pin_drv;
  logic                  gate;
  logic                  gate_oe_n;
  logic                  drain;
  logic                  drain_oe_n;
  logic                  lamp_a;
  logic                  lamp_a_oe_n;
  logic                  lamp_b;
  logic                  lamp_b_oe_n;
  logic                  reload;
  logic                  edv_level;
  logic [31:0]           rd;
  logic                  err;
  int                    fail_count;
  int                    checked;

  always_comb
  begin
    pins = pin_drv;
    pins.above_end_discharge_level = edv_level;
  end

  bcc_charge_ctrl #(.TICK_CYCLES(4)) i_bcc_charge_ctrl (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pins(pins), .charge_gate_out(gate), .charge_gate_oe_n(gate_oe_n),
    .drain_control_out(drain), .drain_control_oe_n(drain_oe_n),
    .status_lamp_a(lamp_a), .status_lamp_a_oe_n(lamp_a_oe_n),
    .status_lamp_b(lamp_b), .status_lamp_b_oe_n(lamp_b_oe_n)
  );

  bcc_cell_model i_bcc_cell_model (
    .pclk(pclk), .reload(reload), .drain_on(drain), .drain_oe_n(drain_oe_n),
    .above_end_level(edv_level)
  );

  task automatic complete_run();
    if (fail_count == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Holds the request until pready is sampled high; the watchdog ends a hang
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic settle();
    repeat (12) @(posedge pclk);
  endtask

  task automatic state_is(input logic [2:0] s);
    apb(1'b0, 12'h004, 32'h0000_0000);
    chk("state", {29'h0, s}, {29'h0, rd[2:0]});
  endtask

  task automatic outs(input logic [3:0] e);
    chk("drive", {28'h0, e}, {28'h0, gate, drain, lamp_a, lamp_b});
  endtask

  task automatic start_cycle();
    apb(1'b1, 12'h000, 32'h0000_0001);
    settle();
  endtask

  task automatic cfg(input bcc_pkg::bcc_tri_type v);
    pin_drv.voltage_term_select <= {v == bcc_pkg::TRI_HIGH, v == bcc_pkg::TRI_LOW};
    pin_drv.lamp_mode_select <= {v == bcc_pkg::TRI_HIGH, v == bcc_pkg::TRI_LOW};
    pin_drv.timer_config_a <= {v == bcc_pkg::TRI_HIGH, v == bcc_pkg::TRI_LOW};
    pin_drv.timer_config_b <= {v == bcc_pkg::TRI_HIGH, v == bcc_pkg::TRI_LOW};
  endtask

  initial
  begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  initial
  begin
    repeat (20000) @(posedge pclk);
    fail_count++;
    complete_run();
  end

  initial
  begin
    bcc_pkg::bcc_tri_type v;
    int n;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    reload = 1'b1;
    fail_count = 0;
    checked = 0;
    pin_drv = '0;
    pin_drv.drain_request_n = 1'b1;
    pin_drv.charge_hold_n = 1'b1;
    pin_drv.current_sense_ref_gnd = 1'b1;
    pin_drv.above_low_temp_fault = 1'b0;
    pin_drv.below_high_temp_fault = 1'b0;
    cfg(bcc_pkg::TRI_LOW);
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    settle();
    state_is(3'h3);
    outs(4'hA);
    apb(1'b0, 12'hFFC, 32'h0000_0000);
    chk("slverr", 32'h1, {31'h0, err});
    chk("unmapped", 32'h0, rd);
    apb(1'b1, 12'h004, 32'h0000_0000);
    pin_drv.peak_voltage_detect <= 1'b1;
    settle();
    state_is(3'h3);
    pin_drv.temp_rate_detect <= 1'b1;
    settle();
    state_is(3'h5);
    outs(4'h1);
    pin_drv.temp_rate_detect <= 1'b0;
    pin_drv.peak_voltage_detect <= 1'b0;
    for (int i = 0; i < 3; i++)
    begin
      v = bcc_pkg::bcc_tri_type'(i);
      cfg(v);
      settle();
      start_cycle();
      apb(1'b0, 12'h004, 32'h0000_0000);
      chk("config", {24'h0, v, v, v, v}, {24'h0, rd[11:4]});
      chk("state", 32'h3, {29'h0, rd[2:0]});
      cfg(bcc_pkg::bcc_tri_type'((i + 1) % 3));
      settle();
      apb(1'b0, 12'h004, 32'h0000_0000);
      chk("latched", {24'h0, v, v, v, v}, {24'h0, rd[11:4]});
      outs(4'hA);
    end
    outs(4'hA);
    pin_drv.peak_voltage_detect <= 1'b1;
    repeat (4) @(posedge pclk);
    pin_drv.peak_voltage_detect <= 1'b0;
    settle();
    state_is(3'h4);
    outs(4'h9);
    cfg(bcc_pkg::TRI_HIGH);
    start_cycle();
    pin_drv.below_temp_cutoff_level <= 1'b1;
    settle();
    state_is(3'h5);
    pin_drv.below_temp_cutoff_level <= 1'b0;
    cfg(bcc_pkg::TRI_LOW);
    pin_drv.above_low_temp_fault <= 1'b1;
    start_cycle();
    state_is(3'h2);
    pin_drv.above_low_temp_fault <= 1'b0;
    settle();
    state_is(3'h3);
    reload <= 1'b0;
    pin_drv.drain_request_n <= 1'b0;
    repeat (4) @(posedge pclk);
    pin_drv.drain_request_n <= 1'b1;
    settle();
    state_is(3'h1);
    outs(4'h4);
    n = 0;
    while (drain !== 1'b0 && n < 200)
    begin
      @(posedge pclk);
      n++;
    end
    settle();
    state_is(3'h2);
    reload <= 1'b1;
    settle();
    state_is(3'h3);
    pin_drv.above_max_cell_level <= 1'b1;
    start_cycle();
    state_is(3'h6);
    outs(4'h0);
    pin_drv.above_max_cell_level <= 1'b0;
    settle();
    state_is(3'h3);
    pin_drv.charge_hold_n <= 1'b0;
    settle();
    chk("oe_n", 32'hF, {28'h0, gate_oe_n, drain_oe_n, lamp_a_oe_n, lamp_b_oe_n});
    state_is(3'h0);
    pin_drv.charge_hold_n <= 1'b1;
    settle();
    state_is(3'h3);
    chk("oe_n", 32'h0, {28'h0, gate_oe_n, drain_oe_n, lamp_a_oe_n, lamp_b_oe_n});
    pin_drv.drain_request_n <= 1'b0;
    pin_drv.charge_hold_n <= 1'b0;
    settle();
    pin_drv.charge_hold_n <= 1'b1;
    settle();
    state_is(3'h1);
    complete_run();
  end
endmodule // battery_charge_control_test

// File: bench/bcc_cell_model.sv
// Behavioural cell front end seen by the charge controller: the end of discharge level.
// Assumes the bench drives every comparator level that is not modelled here.
`timescale 1ns/1ps
module bcc_cell_model (
  input  wire logic pclk,
  input  wire logic reload,
  input  wire logic drain_on,
  input  wire logic drain_oe_n,
  output logic      above_end_level
);
  int level = 0;

  // Only the drain path and reload move the cell; charging is far too slow to matter
  always @(posedge pclk)
  begin
    if (reload)
    begin
      level <= 60;
    end
    else if (drain_on && !drain_oe_n && level > 0)
    begin
      level <= level - 1;
    end
  end

  assign above_end_level = level > 20;
endmodule // bcc_cell_model

// File: src/bcc_charge_ctrl.sv
// Pin-level control of a nickel battery fast charger, with an APB window.
// Assumes comparator levels and three-state pin decodes arrive as plain
// logic levels from an analog front end, asynchronous to pclk.
`timescale 1ns/1ps

module bcc_charge_ctrl #(
  parameter int TICK_CYCLES = bcc_pkg::TICK_PERIOD_NS / bcc_pkg::CLK_PERIOD_NS
) (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [11:0]           paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire bcc_pkg::bcc_pins_type pins,
  output logic                       charge_gate_out,
  output logic                       charge_gate_oe_n,
  output logic                       drain_control_out,
  output logic                       drain_control_oe_n,
  output logic                       status_lamp_a,
  output logic                       status_lamp_a_oe_n,
  output logic                       status_lamp_b,
  output logic                       status_lamp_b_oe_n
);

  localparam logic [27:0] TICK_LAST = 28'(TICK_CYCLES - 1);

  function automatic bcc_pkg::bcc_tri_type tri_decode(input bcc_pkg::bcc_tpin_type p);
    if (p.hi)
      return bcc_pkg::TRI_HIGH;
    else if (p.lo)
      return bcc_pkg::TRI_LOW;
    else
      return bcc_pkg::TRI_FLOAT;
  endfunction

  function automatic logic [15:0] time_limit(input bcc_pkg::bcc_cfg_type c);
    case (c.tm_a)
      bcc_pkg::TRI_LOW:   return bcc_pkg::LIMIT_C4_S;
      bcc_pkg::TRI_FLOAT: return bcc_pkg::LIMIT_C2_S;
      default:
        return (c.tm_b == bcc_pkg::TRI_HIGH) ? bcc_pkg::LIMIT_2C_S : bcc_pkg::LIMIT_1C_S;
    endcase
  endfunction

  function automatic logic [1:0] lamp_pattern(input bcc_pkg::bcc_tri_type m,
                                              input bcc_pkg::bcc_state_type s);
    logic chg;
    chg = (s == bcc_pkg::S_FAST) || (s == bcc_pkg::S_TOPOFF);
    case (m)
      bcc_pkg::TRI_LOW:
        return {chg, s == bcc_pkg::S_MAINT};
      bcc_pkg::TRI_FLOAT:
        return {chg || s == bcc_pkg::S_PEND,
                s == bcc_pkg::S_PEND || s == bcc_pkg::S_ABSENT};
      default:
        return {s == bcc_pkg::S_FAST, s == bcc_pkg::S_TOPOFF || s == bcc_pkg::S_MAINT};
    endcase
  endfunction

  // Pin synchronisers; prev_reg gives the edge history
  bcc_pkg::bcc_pins_type  meta_reg;
  bcc_pkg::bcc_pins_type  pins_reg;
  bcc_pkg::bcc_pins_type  prev_reg;
  bcc_pkg::bcc_state_type state_reg;
  bcc_pkg::bcc_state_type state_next;
  bcc_pkg::bcc_cfg_type   cfg_reg;
  bcc_pkg::bcc_cfg_type   cfg_now;
  bcc_pkg::bcc_drive_type drive_reg;
  bcc_pkg::bcc_drive_type drive_next;
  logic [27:0]            tick_cnt_reg;
  logic [2:0]             phase_reg;
  logic [15:0]            elapsed_reg;
  logic [15:0]            elapsed_next;
  logic [31:0]            prdata_reg;

  // Reset clears the history to hold-low, so release with hold high is a
  // rising edge and doubles as the power-up start.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta_reg <= '0;
      pins_reg <= '0;
      prev_reg <= '0;
    end
    else
    begin
      meta_reg <= pins;
      pins_reg <= meta_reg;
      prev_reg <= pins_reg;
    end
  end

  wire hold_on    = pins_reg.charge_hold_n;
  wire hold_rise  = hold_on & ~prev_reg.charge_hold_n;
  wire drain_fall = ~pins_reg.drain_request_n & prev_reg.drain_request_n;
  wire mcv_fall   = ~pins_reg.above_max_cell_level & prev_reg.above_max_cell_level;

  // APB decode; zero wait states
  wire apb_setup   = psel & ~penable;
  wire apb_access  = psel & penable;
  wire hit_ctrl    = paddr == bcc_pkg::ADDR_CTRL;
  wire hit_status  = paddr == bcc_pkg::ADDR_STATUS;
  wire hit_elapsed = paddr == bcc_pkg::ADDR_ELAPSED;
  wire mapped      = hit_ctrl | hit_status | hit_elapsed;
  wire ctrl_wr     = apb_access & pwrite & hit_ctrl;
  wire sw_start    = ctrl_wr & pwdata[bcc_pkg::CTRL_START_BIT];
  wire sw_drain    = ctrl_wr & pwdata[bcc_pkg::CTRL_DRAIN_BIT];

  assign cfg_now.volt = tri_decode(pins_reg.voltage_term_select);
  assign cfg_now.lamp = tri_decode(pins_reg.lamp_mode_select);
  assign cfg_now.tm_a = tri_decode(pins_reg.timer_config_a);
  assign cfg_now.tm_b = tri_decode(pins_reg.timer_config_b);

  wire in_absent   = state_reg == bcc_pkg::S_ABSENT;
  wire cycle_start = hold_on & (hold_rise | sw_start | (in_absent & mcv_fall));
  wire drain_start = hold_on & (drain_fall | sw_drain |
                                (cycle_start & ~pins_reg.drain_request_n));
  wire drain_done  = (state_reg == bcc_pkg::S_DRAIN) & ~pins_reg.above_end_discharge_level;
  wire cfg_load    = cycle_start | drain_start | drain_done;

  wire pvd_mode = cfg_reg.volt == bcc_pkg::TRI_HIGH;
  wire ndv_mode = cfg_reg.volt == bcc_pkg::TRI_FLOAT;
  wire topoff_en  = cfg_reg.tm_b == bcc_pkg::TRI_HIGH;
  wire trickle_en = cfg_reg.tm_b != bcc_pkg::TRI_LOW;
  wire [15:0] limit_s = time_limit(cfg_reg);
  wire time_up     = elapsed_reg >= limit_s;
  wire past_hold   = elapsed_reg >= bcc_pkg::HOLDOFF_S;

  // Low temperature fault is not enforced in peak detect mode
  wire ltf_fault = pins_reg.above_low_temp_fault & ~pvd_mode;
  wire temp_ok   = ~pins_reg.below_high_temp_fault & ~ltf_fault;
  wire volt_ok   = pins_reg.above_end_discharge_level & ~pins_reg.above_max_cell_level;
  wire qualified = temp_ok & volt_ok;
  wire cutoff    = pins_reg.below_temp_cutoff_level;

  wire fast_term = cutoff | pins_reg.above_max_cell_level | ltf_fault |
                   pins_reg.temp_rate_detect | time_up |
                   (pvd_mode & pins_reg.peak_voltage_detect) |
                   (ndv_mode & past_hold & pins_reg.neg_delta_detect);
  wire top_term  = cutoff | pins_reg.above_max_cell_level | time_up;

  wire tick          = tick_cnt_reg == TICK_LAST;
  wire trickle_pulse = phase_reg == 3'h0;
  wire charging      = (state_reg == bcc_pkg::S_FAST) | (state_reg == bcc_pkg::S_TOPOFF);

  always_comb
  begin
    state_next = state_reg;
    if (!hold_on)
      state_next = bcc_pkg::S_HOLD;
    else if (drain_start)
      state_next = bcc_pkg::S_DRAIN;
    else if (cycle_start)
      state_next = bcc_pkg::S_PEND;
    else
    begin
      case (state_reg)
        bcc_pkg::S_HOLD:   state_next = bcc_pkg::S_HOLD;
        bcc_pkg::S_DRAIN:
          if (drain_done)
            state_next = bcc_pkg::S_PEND;
        bcc_pkg::S_PEND:
          if (pins_reg.above_max_cell_level)
            state_next = bcc_pkg::S_ABSENT;
          else if (qualified)
            state_next = bcc_pkg::S_FAST;
        bcc_pkg::S_FAST:
          // Cutoff skips top-off: an over-temperature cell gets no top-off charge, only the maintenance trickle
          if (fast_term && cutoff)
            state_next = bcc_pkg::S_MAINT;
          else if (fast_term)
            state_next = topoff_en ? bcc_pkg::S_TOPOFF : bcc_pkg::S_MAINT;
        bcc_pkg::S_TOPOFF:
          if (top_term)
            state_next = bcc_pkg::S_MAINT;
        bcc_pkg::S_MAINT:  state_next = bcc_pkg::S_MAINT;
        bcc_pkg::S_ABSENT: state_next = bcc_pkg::S_ABSENT;
        default:           state_next = bcc_pkg::S_HOLD;
      endcase
    end
  end

  // Safety timer restarts on every phase change, so top-off gets its own limit
  always_comb
  begin
    elapsed_next = elapsed_reg;
    if (state_next != state_reg)
      elapsed_next = bcc_pkg::ELAPSED_RESET;
    else if (charging && tick && !time_up)
      elapsed_next = elapsed_reg + 16'h0001;
  end

  always_comb
  begin
    drive_next = '0;
    if (hold_on)
    begin
      if (charging)
        drive_next.gate = pins_reg.current_sense_ref_gnd |
                          pins_reg.current_below_limit;
      else if (state_reg == bcc_pkg::S_PEND)
        drive_next.gate = trickle_pulse;
      else if (state_reg == bcc_pkg::S_MAINT)
        drive_next.gate = trickle_pulse & trickle_en;
      drive_next.drain = state_reg == bcc_pkg::S_DRAIN;
      {drive_next.lamp_a, drive_next.lamp_b} = lamp_pattern(cfg_reg.lamp, state_reg);
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_reg    <= bcc_pkg::S_HOLD;
      cfg_reg      <= '0;
      drive_reg    <= '0;
      elapsed_reg  <= bcc_pkg::ELAPSED_RESET;
      tick_cnt_reg <= 28'h0000000;
      phase_reg    <= 3'h0;
    end
    else
    begin
      state_reg   <= state_next;
      drive_reg   <= drive_next;
      elapsed_reg <= elapsed_next;
      if (cfg_load)
        cfg_reg <= cfg_now;
      tick_cnt_reg <= tick ? 28'h0000000 : tick_cnt_reg + 28'h0000001;
      if (tick)
        phase_reg <= phase_reg + 3'h1;
    end
  end

  // Status word: state, latched config, drive levels, hold level
  wire [31:0] status_word = {15'h0000, hold_on, drive_reg, cfg_reg, 1'b0, state_reg};

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_reg <= 32'h00000000;
    else if (apb_setup)
      prdata_reg <= hit_status  ? status_word :
                    hit_elapsed ? {16'h0000, elapsed_reg} : 32'h00000000;
  end

  assign prdata  = prdata_reg;
  assign pready  = 1'b1;
  assign pslverr = apb_access & ~mapped;

  // Outputs float while held off; the drive levels clear one edge later
  assign charge_gate_out    = drive_reg.gate;
  assign drain_control_out  = drive_reg.drain;
  assign status_lamp_a      = drive_reg.lamp_a;
  assign status_lamp_b      = drive_reg.lamp_b;
  assign charge_gate_oe_n   = ~hold_on;
  assign drain_control_oe_n = ~hold_on;
  assign status_lamp_a_oe_n = ~hold_on;
  assign status_lamp_b_oe_n = ~hold_on;

  default clocking dc @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_cutoff_ends_fast: assert property (
    (state_reg == bcc_pkg::S_FAST || state_reg == bcc_pkg::S_TOPOFF) && cutoff
    |=> state_reg != bcc_pkg::S_FAST && state_reg != bcc_pkg::S_TOPOFF)
    else $error("fast or top-off charge kept past temperature cutoff");

  // Enables follow the hold level at once; the drive levels clear one edge later
  a_hold_floats_all: assert property (
    !hold_on |-> (charge_gate_oe_n && drain_control_oe_n
                  && status_lamp_a_oe_n && status_lamp_b_oe_n)
    ##1 (!charge_gate_out && !drain_control_out && !status_lamp_a && !status_lamp_b))
    else $error("outputs driven while held off");

  a_hold_rise_start: assert property (
    hold_rise |=> state_reg == bcc_pkg::S_PEND || state_reg == bcc_pkg::S_DRAIN)
    else $error("hold release did not start a charge cycle");

  a_drain_from_any: assert property (
    hold_on && drain_fall |=> state_reg == bcc_pkg::S_DRAIN ##1 drain_control_out)
    else $error("drain request edge did not start draining");

  a_drain_ends_low: assert property (
    drain_done && hold_on && !drain_start && !cycle_start
    |=> state_reg == bcc_pkg::S_PEND ##1 !drain_control_out)
    else $error("drain did not end at end of discharge level");

  a_gate_blocked: assert property (
    state_reg inside {bcc_pkg::S_DRAIN, bcc_pkg::S_ABSENT, bcc_pkg::S_HOLD}
    |=> !charge_gate_out)
    else $error("charge gate on outside a charging state");

  a_gate_plain_on: assert property (
    hold_on && charging && pins_reg.current_sense_ref_gnd |=> charge_gate_out)
    else $error("gate not on while charging with grounded sense ref");

  a_fast_qualified: assert property (
    $rose(state_reg == bcc_pkg::S_FAST) |-> $past(qualified))
    else $error("fast charge entered without qualification");

  a_cfg_held: assert property (
    !cfg_load |=> $stable(cfg_reg))
    else $error("configuration changed inside a charge cycle");

  a_unmapped_err: assert property (
    apb_access && !mapped |-> pslverr && pready)
    else $error("unmapped access not answered with an error");

  a_pend_trickles: assert property (
    hold_on && state_reg == bcc_pkg::S_PEND |=> charge_gate_out == $past(trickle_pulse))
    else $error("pending state gate does not follow the trickle pulse");

  a_absent_on_max: assert property (
    hold_on && state_reg == bcc_pkg::S_PEND && pins_reg.above_max_cell_level
    && !drain_start && !cycle_start |=> state_reg == bcc_pkg::S_ABSENT)
    else $error("over-voltage cell not treated as absent");

  a_term_leaves_fast: assert property (
    hold_on && state_reg == bcc_pkg::S_FAST && fast_term && !drain_start && !cycle_start
    |=> state_reg inside {bcc_pkg::S_TOPOFF, bcc_pkg::S_MAINT})
    else $error("fast charge kept after a termination condition");

  a_maint_gate_off: assert property (
    state_reg == bcc_pkg::S_MAINT && !trickle_en |=> !charge_gate_out)
    else $error("maintenance gate pulsed with trickle disabled");

endmodule // bcc_charge_ctrl

// File: src/bcc_pkg.sv
// Shared types and constants of the charge control block.
// Assumes one 250 MHz clock and comparator results already in digital form.
package bcc_pkg;

  typedef enum logic [1:0] {TRI_LOW, TRI_FLOAT, TRI_HIGH} bcc_tri_type;

  typedef enum logic [2:0] {
    S_HOLD, S_DRAIN, S_PEND, S_FAST, S_TOPOFF, S_MAINT, S_ABSENT
  } bcc_state_type;

  // Three-state pin seen through two comparators: above high, below low
  typedef struct packed {
    logic hi;
    logic lo;
  } bcc_tpin_type;

  typedef struct packed {
    logic         drain_request_n;
    logic         charge_hold_n;
    logic         current_sense_ref_gnd;
    logic         current_below_limit;
    logic         above_end_discharge_level;
    logic         above_max_cell_level;
    logic         below_temp_cutoff_level;
    logic         above_low_temp_fault;
    logic         below_high_temp_fault;
    logic         temp_rate_detect;
    logic         peak_voltage_detect;
    logic         neg_delta_detect;
    bcc_tpin_type voltage_term_select;
    bcc_tpin_type lamp_mode_select;
    bcc_tpin_type timer_config_a;
    bcc_tpin_type timer_config_b;
  } bcc_pins_type;

  typedef struct packed {
    bcc_tri_type volt;
    bcc_tri_type lamp;
    bcc_tri_type tm_a;
    bcc_tri_type tm_b;
  } bcc_cfg_type;

  typedef struct packed {
    logic gate;
    logic drain;
    logic lamp_a;
    logic lamp_b;
  } bcc_drive_type;

  localparam int unsigned CLK_PERIOD_NS  = 32'h0000_0004;
  localparam int unsigned TICK_PERIOD_NS = 32'h3B9A_CA00;

  localparam logic [11:0] ADDR_CTRL    = 12'h000;
  localparam logic [11:0] ADDR_STATUS  = 12'h004;
  localparam logic [11:0] ADDR_ELAPSED = 12'h008;

  localparam int CTRL_START_BIT = 32'h0;
  localparam int CTRL_DRAIN_BIT = 32'h1;

  localparam logic [15:0] ELAPSED_RESET = 16'h0000;
  localparam logic [15:0] LIMIT_C4_S    = 16'h1C20;
  localparam logic [15:0] LIMIT_C2_S    = 16'h0E10;
  localparam logic [15:0] LIMIT_1C_S    = 16'h0708;
  localparam logic [15:0] LIMIT_2C_S    = 16'h0384;
  localparam logic [15:0] HOLDOFF_S     = 16'h0096;

endpackage
